// [sram_host_ctrl.sv]
// Summary of operation
// - Read cycle lasts at least 15 ns; data sampled after 15 ns access.
// - Read: write strobe high, select and output gate low.
// - Select-controlled read: address valid by select falling.
// - Writes spaced 15 ns apart, strobe low at least 10 ns.
// - Select low at least 10 ns before write end.
// - Address valid 10 ns before write end, settled at write start.
// - Address stable until write end; next access may follow at once.
// - Write data valid 7 ns before write end, held to end.
// - Select or strobe high whenever address changes.
// - Read timing measured last valid address to next transition.
// - Write timing measured last valid address to next transition.
// - Host drives data only after memory outputs are disabled.
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl (
  input  wire logic                            i_mclk,
  input  wire logic                            i_nrst,
  input  wire logic                            i_req_valid,
  input  wire logic                            i_req_write,
  input  wire logic [sram_ctrl_pkg::ADDR_W-1:0] i_req_addr,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0] i_req_wdata,
  output logic                                 o_req_ready,
  output logic                                 o_rsp_valid,
  output logic [sram_ctrl_pkg::DATA_W-1:0]      o_rsp_rdata,
  output logic                                 o_wr_done,
  output logic [sram_ctrl_pkg::ADDR_W-1:0]      o_addr,
  output logic                                 o_sel_n,
  output logic                                 o_wstb_n,
  output logic                                 o_ogate_n,
  output logic [sram_ctrl_pkg::DATA_W-1:0]      o_shared_data_pins_out,
  output logic                                 o_shared_data_pins_oe,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0] i_shared_data_pins_in
);
  import sram_ctrl_pkg::*;

  // ------------------------------------------------------------
  // Pin bundle and state
  // ------------------------------------------------------------
  sram_pins_if pins ();

  phase_e            phase_q;
  logic              after_read_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              sel_n_q;
  logic              wstb_n_q;
  logic              ogate_n_q;
  logic              doe_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rsp_valid_q;
  logic              wr_done_q;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_value;
  logic              tmr_done;
  logic              accept;

  // Phase length for each step of the sequence
  function automatic logic [CNT_W-1:0] phase_len(input phase_e ph, input logic rd_before);
    case (ph)
      PH_READ:  phase_len = CNT_W'(RD_CYC - 1);
      PH_WRITE: phase_len = CNT_W'(((WR_CYC > WC_CYC) ? WR_CYC : WC_CYC) - 1);
      PH_GAP:   phase_len = rd_before ? CNT_W'(TA_CYC) : CNT_ZERO;
      default:  phase_len = CNT_ZERO;
    endcase
  endfunction : phase_len

  // ------------------------------------------------------------
  // Phase decode
  // ------------------------------------------------------------
  // Last cycle of a read or write phase
  function automatic logic access_ends(input phase_e ph, input logic done);
    access_ends = ((ph == PH_READ) || (ph == PH_WRITE)) && done;
  endfunction : access_ends

  // Last cycle of a read phase
  function automatic logic is_read_end(input phase_e ph, input logic done);
    is_read_end = (ph == PH_READ) && done;
  endfunction : is_read_end

  // Last cycle of a write phase
  function automatic logic is_write_end(input phase_e ph, input logic done);
    is_write_end = (ph == PH_WRITE) && done;
  endfunction : is_write_end

  // ------------------------------------------------------------
  // Request handshake
  // ------------------------------------------------------------
  assign o_req_ready = (phase_q == PH_IDLE);
  assign accept      = i_req_valid && o_req_ready;

  // ------------------------------------------------------------
  // Phase sequencer
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_q <= PH_IDLE;
    end else begin
      case (phase_q)
        PH_IDLE:  if (accept) phase_q <= i_req_write ? PH_WRITE : PH_READ;
        PH_READ:  if (tmr_done) phase_q <= PH_GAP;
        PH_WRITE: if (tmr_done) phase_q <= PH_GAP;
        PH_GAP:   if (tmr_done) phase_q <= PH_IDLE;
        default:  phase_q <= PH_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Timer load
  // ------------------------------------------------------------
  // Timer load on entry to each read, write or gap phase
  always_comb begin
    tmr_load  = 1'b0;
    tmr_value = CNT_ZERO;
    if (accept) begin
      tmr_load  = 1'b1;
      tmr_value = phase_len(i_req_write ? PH_WRITE : PH_READ, 1'b0);
    end else if (access_ends(phase_q, tmr_done)) begin
      tmr_load  = 1'b1;
      tmr_value = phase_len(PH_GAP, phase_q == PH_READ);
    end
  end

  // ------------------------------------------------------------
  // Phase timer
  // ------------------------------------------------------------
  // Down counter that sets the length of each read, write and gap phase
  sram_cycle_timer u_timer (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_load  (tmr_load),
    .i_value (tmr_value),
    .o_done  (tmr_done)
  );

  // ------------------------------------------------------------
  // Address and write data capture
  // ------------------------------------------------------------
  // Address changes only in idle while select and strobe are high
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_q <= '0;
    end else if (accept) begin
      addr_q <= i_req_addr;
    end
  end

  // Write data latched with the request, held through the phase
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdata_q <= '0;
    end else if (accept) begin
      wdata_q <= i_req_wdata;
    end
  end

  // ------------------------------------------------------------
  // Turnaround memory
  // ------------------------------------------------------------
  // Remember whether the last access was a read
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      after_read_q <= 1'b0;
    end else if (accept) begin
      after_read_q <= !i_req_write;
    end
  end

  // ------------------------------------------------------------
  // Control strobes
  // ------------------------------------------------------------
  // Select low with the new address, high at the end of the access
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_n_q <= 1'b1;
    end else if (accept) begin
      sel_n_q <= 1'b0;
    end else if (access_ends(phase_q, tmr_done)) begin
      sel_n_q <= 1'b1;
    end
  end

  // Write strobe low only for writes, rising together with select
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wstb_n_q <= 1'b1;
    end else if (accept) begin
      wstb_n_q <= !i_req_write;
    end else if (access_ends(phase_q, tmr_done)) begin
      wstb_n_q <= 1'b1;
    end
  end

  // Output gate low only for reads, for the whole access window
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ogate_n_q <= 1'b1;
    end else if (accept) begin
      ogate_n_q <= i_req_write;
    end else if (access_ends(phase_q, tmr_done)) begin
      ogate_n_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Write data driver
  // ------------------------------------------------------------
  // Host data driver: on only for writes, dropped with the strobe
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      doe_q <= 1'b0;
    end else if (accept) begin
      doe_q <= i_req_write && !after_read_q;
    end else if (phase_q == PH_WRITE && !tmr_done) begin
      doe_q <= 1'b1;
    end else begin
      doe_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Responses
  // ------------------------------------------------------------
  // Read data sampled at the end of the access window
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= '0;
    end else if (is_read_end(phase_q, tmr_done)) begin
      rdata_q <= pins.din;
    end
  end

  // ------------------------------------------------------------
  // Response pulse
  // ------------------------------------------------------------
  // One-cycle pulse in the same cycle that the sampled data appears
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= is_read_end(phase_q, tmr_done);
    end
  end

  // ------------------------------------------------------------
  // Write completion
  // ------------------------------------------------------------
  // Pulse in the same cycle that select and strobe rise
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_done_q <= 1'b0;
    end else begin
      wr_done_q <= is_write_end(phase_q, tmr_done);
    end
  end

  // ------------------------------------------------------------
  // Response outputs
  // ------------------------------------------------------------
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_rdata = rdata_q;
  assign o_wr_done   = wr_done_q;

  // ------------------------------------------------------------
  // Pin stage
  // ------------------------------------------------------------
  // Registered strobes and data onto the pin bundle
  assign pins.addr    = addr_q;
  assign pins.sel_n   = sel_n_q;
  assign pins.wstb_n  = wstb_n_q;
  assign pins.ogate_n = ogate_n_q;
  assign pins.dout    = wdata_q;
  assign pins.doe     = doe_q;

  sram_pin_stage u_pins (
    .pins       (pins),
    .i_data_in  (i_shared_data_pins_in),
    .o_addr     (o_addr),
    .o_sel_n    (o_sel_n),
    .o_wstb_n   (o_wstb_n),
    .o_ogate_n  (o_ogate_n),
    .o_data_out (o_shared_data_pins_out),
    .o_data_oe  (o_shared_data_pins_oe)
  );
endmodule : sram_host_ctrl
`default_nettype wire

// [sram_ctrl_pkg.sv]
package sram_ctrl_pkg;
  // ------------------------------------------------------------
  // Memory geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;

  // ------------------------------------------------------------
  // Pin timing in ns and derived cycle counts at 100 MHz
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_RC_NS       = 15;
  localparam int T_AA_NS       = 15;
  localparam int T_OE_NS       = 7;
  localparam int T_WC_NS       = 15;
  localparam int T_WP_NS       = 10;
  localparam int T_CW_NS       = 10;
  localparam int T_AW_NS       = 10;
  localparam int T_DW_NS       = 7;
  localparam int T_CHZ_NS      = 7;
  localparam int T_OHZ_NS      = 6;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  // Read sample point covers access time plus one spare cycle of margin before the sample
  localparam int RD_ACC_NS  = (T_AA_NS > T_RC_NS) ? T_AA_NS : T_RC_NS;
  localparam int RD_CYC     = ns_to_cyc(RD_ACC_NS) + 1;
  // Strobe low time covers pulse width, select-to-end and address setup
  localparam int WR_LO_NS   = (T_WP_NS > T_CW_NS) ? T_WP_NS : T_CW_NS;
  localparam int WR_CYC     = ns_to_cyc((WR_LO_NS > T_AW_NS) ? WR_LO_NS : T_AW_NS);
  localparam int WC_CYC     = ns_to_cyc(T_WC_NS);
  // Turnaround after a read: memory output release before host drives
  localparam int TA_NS      = (T_CHZ_NS > T_OHZ_NS) ? T_CHZ_NS : T_OHZ_NS;
  localparam int TA_CYC     = ns_to_cyc(TA_NS);
  localparam int CNT_W      = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_WRITE,
    PH_GAP
  } phase_e;
endpackage : sram_ctrl_pkg

// [sram_pins_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sram_pins_if;
  import sram_ctrl_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              sel_n;
  logic              wstb_n;
  logic              ogate_n;
  logic [DATA_W-1:0] dout;
  logic              doe;
  logic [DATA_W-1:0] din;
  modport seq (output addr, sel_n, wstb_n, ogate_n, dout, doe, input din);
  modport pad (input addr, sel_n, wstb_n, ogate_n, dout, doe, output din);
endinterface : sram_pins_if
`default_nettype wire

// [sram_cycle_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module sram_cycle_timer (
  input  wire logic                            i_mclk,
  input  wire logic                            i_nrst,
  input  wire logic                            i_load,
  input  wire logic [sram_ctrl_pkg::CNT_W-1:0] i_value,
  output logic                                 o_done
);
  import sram_ctrl_pkg::*;

  logic [CNT_W-1:0] cnt_q;

  // Down counter, loaded at phase start
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= CNT_ZERO;
    end else if (i_load) begin
      cnt_q <= i_value;
    end else if (cnt_q != CNT_ZERO) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // Plain count compare: the load is decoded from done, so done must not see the load
  assign o_done = (cnt_q == CNT_ZERO);
endmodule : sram_cycle_timer
`default_nettype wire

// [sram_pin_stage.sv]
`timescale 1ns/1ps
`default_nettype none
module sram_pin_stage (
  sram_pins_if.pad                              pins,
  input  wire logic [sram_ctrl_pkg::DATA_W-1:0] i_data_in,
  output logic [sram_ctrl_pkg::ADDR_W-1:0]      o_addr,
  output logic                                  o_sel_n,
  output logic                                  o_wstb_n,
  output logic                                  o_ogate_n,
  output logic [sram_ctrl_pkg::DATA_W-1:0]      o_data_out,
  output logic                                  o_data_oe
);
  import sram_ctrl_pkg::*;

  // Pins driven straight from the sequencer flops
  assign o_addr     = pins.addr;
  assign o_sel_n    = pins.sel_n;
  assign o_wstb_n   = pins.wstb_n;
  assign o_ogate_n  = pins.ogate_n;
  assign o_data_out = pins.dout;
  assign o_data_oe  = pins.doe;
  assign pins.din   = i_data_in;
endmodule : sram_pin_stage
`default_nettype wire

// [sram_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sram_mem_model (
  input  wire logic        i_mclk,
  input  wire logic [14:0] i_addr,
  input  wire logic        i_sel_n,
  input  wire logic        i_wstb_n,
  input  wire logic        i_ogate_n,
  input  wire logic [7:0]  i_dout,
  input  wire logic        i_oe,
  output wire logic [7:0]  o_bus
);
  // ----
  // Storage and pin drive
  // ----
  logic [7:0]  mem [0:32767];
  logic [7:0]  last = 8'h00;
  logic [7:0]  d_q  = 8'h00;
  logic [14:0] a_q  = 15'h0000;
  logic        wr_q = 1'b0;
  wire         drv;
  wire  [7:0]  rd_d;
  // Drive only in a read, a few ns after select and gate
  assign #4 drv = !i_sel_n && !i_ogate_n && i_wstb_n;
  assign #3 rd_d = mem[i_addr];
  // Contention shows as unknown; a floating bus toggles
  assign o_bus = (i_oe && drv) ? 8'hXX : i_oe ? i_dout : drv ? rd_d : ~last;
  // Commit on the first rising of select or strobe
  always @(posedge i_mclk) begin
    if (wr_q && (i_sel_n || i_wstb_n)) begin
      mem[a_q] <= d_q;
    end
    wr_q <= !i_sel_n && !i_wstb_n;
    a_q  <= i_addr;
    d_q  <= o_bus;
    last <= o_bus;
  end
endmodule : sram_mem_model
`default_nettype wire

// [sram_host_ctrl_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_sva (
  input  wire logic                             i_mclk,
  input  wire logic                             i_nrst,
  input  wire logic                             o_rsp_valid,
  input  wire logic                             o_wr_done,
  input  wire logic [sram_ctrl_pkg::ADDR_W-1:0] o_addr,
  input  wire logic                             o_sel_n,
  input  wire logic                             o_wstb_n,
  input  wire logic                             o_ogate_n,
  input  wire logic                             o_shared_data_pins_oe
);
  import sram_ctrl_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // ----
  // Pin sequences
  // ----
  sequence s_rd_low;
    (!o_ogate_n && !o_sel_n && o_wstb_n)[*3];
  endsequence
  sequence s_wr_low;
    (!o_wstb_n && !o_sel_n)[*2];
  endsequence
  chk_read_pins: assert property (!o_ogate_n |-> !o_sel_n && o_wstb_n)
    else $error("read pins wrong");
  chk_read_len: assert property ($fell(o_ogate_n) |-> s_rd_low ##1 o_ogate_n)
    else $error("read length wrong");
  chk_rsp_after: assert property ($rose(o_ogate_n) |-> o_rsp_valid)
    else $error("read response late");
  chk_wr_len: assert property ($fell(o_wstb_n) |-> s_wr_low ##1 (o_wstb_n && o_sel_n))
    else $error("write pulse wrong");
  chk_wr_space: assert property ($rose(o_wstb_n) |-> o_wstb_n[*2])
    else $error("writes too close");
  chk_addr_hold: assert property (!o_sel_n && !$past(o_sel_n) |-> $stable(o_addr))
    else $error("address moved while selected");
  chk_wr_data: assert property (!o_wstb_n && !$past(o_wstb_n) |-> o_shared_data_pins_oe)
    else $error("write data not driven");
  chk_no_clash: assert property (o_shared_data_pins_oe |-> o_ogate_n && $past(o_ogate_n))
    else $error("host drives during read");
  chk_end_both: assert property ($rose(o_wstb_n) |-> $rose(o_sel_n) && o_wr_done)
    else $error("write end wrong");
  chk_turn_gap: assert property ($rose(o_ogate_n) |-> (!o_shared_data_pins_oe)[*4])
    else $error("host drives too soon after read");
endmodule : sram_host_ctrl_sva
bind sram_host_ctrl sram_host_ctrl_sva sram_host_ctrl_sva_inst (.i_mclk, .i_nrst, .o_rsp_valid, .o_wr_done,
  .o_addr, .o_sel_n, .o_wstb_n, .o_ogate_n, .o_shared_data_pins_oe);
`default_nettype wire

// [sram_host_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sram_host_ctrl_tb_top;
  import sram_ctrl_pkg::*;
  logic              i_mclk = 1'b0;
  logic              i_nrst = 1'b0;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr  = 15'h0000;
  logic [DATA_W-1:0] req_wdata = 8'h00;
  logic              ready, rsp_valid, wr_done, sel_n, wstb_n, ogate_n, doe;
  logic [DATA_W-1:0] rdata, dout;
  logic [ADDR_W-1:0] addr;
  wire  [DATA_W-1:0] bus;
  int                err_total = 0;
  int                n_compared = 0;
  // Clock
  always begin
    #5;
    i_mclk = ~i_mclk;
  end
  sram_host_ctrl sram_host_ctrl_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req_valid(req_valid),
    .i_req_write(req_write), .i_req_addr(req_addr), .i_req_wdata(req_wdata), .o_req_ready(ready),
    .o_rsp_valid(rsp_valid), .o_rsp_rdata(rdata), .o_wr_done(wr_done), .o_addr(addr), .o_sel_n(sel_n),
    .o_wstb_n(wstb_n), .o_ogate_n(ogate_n), .o_shared_data_pins_out(dout), .o_shared_data_pins_oe(doe),
    .i_shared_data_pins_in(bus));
  sram_mem_model sram_mem_model_inst (.i_mclk(i_mclk), .i_addr(addr), .i_sel_n(sel_n), .i_wstb_n(wstb_n),
    .i_ogate_n(ogate_n), .i_dout(dout), .i_oe(doe), .o_bus(bus));
  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // One request, held until taken, then wait for its answer
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = a;
    req_wdata = d;
    do begin
      @(posedge i_mclk);
      n++;
    end while (ready !== 1'b1 && n < 50);
    #1;
    req_valid = 1'b0;
    while ((wr ? wr_done : rsp_valid) !== 1'b1 && n < 50) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    q = rdata;
    if (n >= 50) begin
      check("handshake", 32'h0, 32'h1);
    end
  endtask : access
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    access(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string what);
    logic [DATA_W-1:0] q;
    access(1'b0, a, 8'h00, q);
    check(what, {24'h0, q}, {24'h0, e});
  endtask : rd_chk
  // ----
  // Scenarios
  // ----
  task automatic t_edges();
    wr(15'h0000, 8'hA5);
    wr(15'h7FFF, 8'h5A);
    rd_chk(15'h0000, 8'hA5, "lowest word");
    rd_chk(15'h7FFF, 8'h5A, "highest word");
    $display("t_edges done");
  endtask : t_edges
  task automatic t_turn();
    rd_chk(15'h7FFF, 8'h5A, "read before write");
    wr(15'h7FFF, 8'hC3);
    rd_chk(15'h7FFF, 8'hC3, "write after read");
    wr(15'h0001, 8'h81);
    wr(15'h0002, 8'h7E);
    rd_chk(15'h0001, 8'h81, "first of pair");
    rd_chk(15'h0002, 8'h7E, "second of pair");
    $display("t_turn done");
  endtask : t_turn
  task automatic t_keep();
    wr(15'h1234, 8'h0F);
    wr(15'h1234, 8'hF0);
    repeat (40) @(posedge i_mclk);
    #1;
    rd_chk(15'h1234, 8'hF0, "overwritten word");
    rd_chk(15'h0000, 8'hA5, "untouched word");
    check("idle select", {31'h0, sel_n}, 32'h1);
    check("idle strobe", {31'h0, wstb_n}, 32'h1);
    check("idle data enable", {31'h0, doe}, 32'h0);
    check("idle gate", {31'h0, ogate_n}, 32'h1);
    $display("t_keep done");
  endtask : t_keep
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    repeat (12) @(posedge i_mclk);
    #1;
    i_nrst = 1'b1;
    t_edges();
    t_turn();
    t_keep();
    close_out();
  end
  // Watchdog
  initial begin
    #50000;
    err_total++;
    close_out();
  end
endmodule : sram_host_ctrl_tb_top
`default_nettype wire
